// file: design/fan_pwm_fault_supervisor.sv
/*
  fan speed pwm controller with spin-up, missing-pulse detection,
  diagnostic and restart sequencing and latched fan failure.
  assumes duty codes and shutdown level come from logic on clk_in;
  sense pulses arrive asynchronously from the fan.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fan_pwm_defines.svh"
// Notes on behaviour
// - duty rises linearly with control code, zero code 0%, full code 100%
// - minimum-speed code sets a floor for the duty cycle
// - each period uses the greater of temperature and minimum codes
// - shutdown request at or below threshold suspends everything
// - drive duty held at zero during shutdown
// - failure output released while in shutdown
// - release above threshold resumes exactly as after power-up
// - entering shutdown clears latched failure and all timers
// - shutdown overrides temperature control, drive stays off
// - start from off drives fan fully on for 32 periods
// - spin-up, diagnostic and missing-pulse intervals count pwm ramp periods; blanking counts clk_in cycles
// - pulses coinciding with drive switch-on are blanked
// - valid pulse in normal restarts missing-pulse detector
// - 32 pulseless periods in normal start the diagnostic interval
// - diagnostic drives fully on three periods, watching for pulse
// - no pulse in diagnostic runs one spin-up, once per fault
// - timeout after recovery stops drive, asserts failure, latches
// - latched failure persists until shutdown pulse or power cycle
// - failure output active low, only for fan failure
// - fan drive active high
// - pulse during first spin-up goes straight to normal
// - no pulse: second 32-period spin-up, then latched failure
// - failure fed back to shutdown input resets and retries
module fan_pwm_fault_supervisor
  import fan_pwm_pkg::*;
#(
  parameter int unsigned TICK_DIV = `TICK_DIV_DEFAULT,
  parameter int unsigned BLANK_CYCLES = `BLANK_CYCLES_DEFAULT
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // control levels
  input wire logic [`CODE_W-1:0] temp_code_in,
  input wire logic [`CODE_W-1:0] min_code_in,
  input wire logic shutdown_in,
  // fan side
  input wire logic sense_in,
  output logic drive_out,
  output logic fail_n_out
);
  sup_state_t state;
  sup_state_t next_state;
  logic [`PERIOD_CNT_W-1:0] cnt;
  logic [`PERIOD_CNT_W-1:0] next_cnt;
  logic recovered;
  logic next_recovered;
  logic next_drive;
  logic next_fail_n;
  logic [`CODE_W-1:0] duty_code;
  logic period_start;
  logic pwm_active;
  logic pulse;
  logic run;

  function automatic logic [`CODE_W-1:0] max_code(input logic [`CODE_W-1:0] a,
                                                  input logic [`CODE_W-1:0] b);
    max_code = (a > b) ? a : b;
  endfunction : max_code

  assign duty_code = max_code(temp_code_in, min_code_in);
  assign run = (state != st_shutdown) && (state != st_fault);

  pwm_ramp #(
    .TICK_DIV(TICK_DIV)
  ) u_ramp (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .run_in(run),
    .duty_in(duty_code),
    .period_start_out(period_start),
    .active_out(pwm_active)
  );

  sense_pulse #(
    .BLANK_CYCLES(BLANK_CYCLES)
  ) u_sense (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .sense_in(sense_in),
    .drive_in(drive_out),
    .pulse_out(pulse)
  );

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_recovered = recovered;
    if (shutdown_in) begin
      next_state = st_shutdown;
      next_cnt = 6'h00;
      next_recovered = 1'b0;
    end else begin
      case (state)
        st_shutdown: begin
          next_state = st_spinup1;
          next_cnt = 6'h00;
        end
        st_spinup1: begin
          if (pulse) begin
            next_state = st_normal;
            next_cnt = 6'h00;
          end else if (period_start) begin
            next_cnt = cnt + 6'h01;
            if (cnt == `SPINUP_CYCLES - 6'h01) begin
              next_state = st_spinup2;
              next_cnt = 6'h00;
            end
          end
        end
        st_spinup2: begin
          if (pulse) begin
            next_state = st_normal;
            next_cnt = 6'h00;
          end else if (period_start) begin
            next_cnt = cnt + 6'h01;
            if (cnt == `SPINUP_CYCLES - 6'h01) begin
              next_state = st_fault;
            end
          end
        end
        st_normal: begin
          if (pulse) begin
            next_cnt = 6'h00;
          end else if (period_start) begin
            next_cnt = cnt + 6'h01;
            if (cnt == `MISSING_PULSE_CYCLES - 6'h01) begin
              next_cnt = 6'h00;
              // first timeout after a recovery is fatal
              next_state = recovered ? st_fault : st_diag;
            end
          end
        end
        st_diag: begin
          if (pulse) begin
            next_state = st_normal;
            next_cnt = 6'h00;
          end else if (period_start) begin
            next_cnt = cnt + 6'h01;
            if (cnt == `DIAG_CYCLES - 6'h01) begin
              next_state = st_recover;
              next_cnt = 6'h00;
            end
          end
        end
        st_recover: begin
          if (pulse) begin
            next_state = st_normal;
            next_cnt = 6'h00;
            next_recovered = 1'b1;
          end else if (period_start) begin
            next_cnt = cnt + 6'h01;
            if (cnt == `SPINUP_CYCLES - 6'h01) begin
              next_state = st_fault;
            end
          end
        end
        st_fault: begin
          next_state = st_fault;
        end
        default: begin
          next_state = st_shutdown;
          next_cnt = 6'h00;
          next_recovered = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    case (next_state)
      st_spinup1, st_spinup2, st_recover, st_diag: next_drive = 1'b1;
      st_normal: next_drive = pwm_active;
      default: next_drive = 1'b0;
    endcase
    next_fail_n = !(next_state == st_fault);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= st_shutdown;
      cnt <= 6'h00;
      recovered <= 1'b0;
      drive_out <= 1'b0;
      fail_n_out <= 1'b1;
    end else if (ce_in) begin
      state <= next_state;
      cnt <= next_cnt;
      recovered <= next_recovered;
      drive_out <= next_drive;
      fail_n_out <= next_fail_n;
    end
  end
endmodule : fan_pwm_fault_supervisor
`default_nettype wire

// file: design/fan_pwm_defines.svh
/*
  timing counts and widths for the fan pwm fault supervisor.
  assumes inclusion by bare name from design files only.
*/
`ifndef FAN_PWM_DEFINES_SVH
`define FAN_PWM_DEFINES_SVH

`define CODE_W 8
`define RAMP_MAX 8'hff
`define SPINUP_CYCLES 6'h20
`define MISSING_PULSE_CYCLES 6'h20
`define DIAG_CYCLES 6'h03
`define TICK_DIV_DEFAULT 32'd13020
`define PERIOD_CNT_W 6
`define BLANK_CYCLES_DEFAULT 16

`endif

// file: design/fan_pwm_pkg.sv
/*
  types shared by the fan pwm fault supervisor.
  assumes nothing of its surroundings.
*/
package fan_pwm_pkg;
  typedef enum logic [2:0] {
    st_shutdown = 3'b000,
    st_spinup1 = 3'b001,
    st_spinup2 = 3'b010,
    st_normal = 3'b011,
    st_diag = 3'b100,
    st_recover = 3'b101,
    st_fault = 3'b110
  } sup_state_t;
endpackage : fan_pwm_pkg

// file: design/pwm_ramp.sv
/*
  pwm ramp counter with period-start strobe and duty compare.
  assumes clk_in is the system clock; duty code sampled once per period.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fan_pwm_defines.svh"
module pwm_ramp #(
  parameter int unsigned TICK_DIV = `TICK_DIV_DEFAULT
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // control
  input wire logic run_in,
  input wire logic [`CODE_W-1:0] duty_in,
  // outputs
  output logic period_start_out,
  output logic active_out
);
  logic [31:0] div;
  logic [`CODE_W-1:0] ramp;
  logic [`CODE_W-1:0] duty;
  logic [31:0] next_div;
  logic [`CODE_W-1:0] next_ramp;
  logic [`CODE_W-1:0] next_duty;
  logic tick;

  always_comb begin
    tick = (div == TICK_DIV - 1);
    next_div = tick ? 32'h0 : div + 32'h1;
    next_ramp = ramp;
    next_duty = duty;
    if (!run_in) begin
      next_div = 32'h0;
      next_ramp = 8'h00;
      next_duty = duty_in;
    end else if (tick) begin
      next_ramp = (ramp == `RAMP_MAX - 8'h01) ? 8'h00 : ramp + 8'h01;
      // latch duty at period start so a period never glitches
      if (ramp == `RAMP_MAX - 8'h01) begin
        next_duty = duty_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div <= 32'h0;
      ramp <= 8'h00;
      duty <= 8'h00;
    end else if (ce_in) begin
      div <= next_div;
      ramp <= next_ramp;
      duty <= next_duty;
    end
  end

  // full code means 100%: ramp runs 0..254
  assign period_start_out = run_in && tick && (ramp == `RAMP_MAX - 8'h01);
  assign active_out = run_in && (ramp < duty);
endmodule : pwm_ramp
`default_nettype wire

// file: design/sense_pulse.sv
/*
  fan pulse synchroniser, edge detector and switch-on blanking.
  assumes sense_in is asynchronous logic-level pulse train.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fan_pwm_defines.svh"
module sense_pulse #(
  parameter int unsigned BLANK_CYCLES = `BLANK_CYCLES_DEFAULT
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // inputs
  input wire logic sense_in,
  input wire logic drive_in,
  // output
  output logic pulse_out
);
  logic s1;
  logic s2;
  logic s3;
  logic drive_d;
  logic [7:0] blank;
  logic [7:0] next_blank;
  logic edge_seen;

  always_comb begin
    next_blank = (blank != 8'h00) ? blank - 8'h01 : 8'h00;
    // drive switching on chops fan current and fakes a pulse
    if (drive_in && !drive_d) begin
      next_blank = 8'(BLANK_CYCLES);
    end
    edge_seen = s2 && !s3;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      drive_d <= 1'b0;
      blank <= 8'h00;
      pulse_out <= 1'b0;
    end else if (ce_in) begin
      s1 <= sense_in;
      s2 <= s1;
      s3 <= s2;
      drive_d <= drive_in;
      blank <= next_blank;
      pulse_out <= edge_seen && (blank == 8'h00) && !(drive_in && !drive_d);
    end
  end
endmodule : sense_pulse
`default_nettype wire

// file: testbench/fan_sup_asserts.sv
/* port checks for the fan supervisor.
   assumes binding to every supervisor instance. */
`timescale 1ns/1ps
`default_nettype none
module fan_sup_asserts #(
  parameter int unsigned TICK_DIV = 2
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // watched pins
  input wire logic shutdown_in,
  input wire logic drive_out,
  input wire logic fail_n_out
);
  // two spin-ups must run before any failure; slack for sync edges
  localparam int MIN_FAIL = 64 * 255 * TICK_DIV - 8;
  logic [31:0] run_cnt;
  logic [31:0] next_run_cnt;
  always_comb begin
    next_run_cnt = run_cnt;
    // shutdown is ignored while frozen, so the count must be too
    if (ce_in && shutdown_in) begin
      next_run_cnt = '0;
    end else if (ce_in && !(&run_cnt)) begin
      next_run_cnt = run_cnt + 32'h1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      run_cnt <= '0;
    end else begin
      run_cnt <= next_run_cnt;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_shutdown_drive_off: assert property (ce_in && shutdown_in |=> !drive_out)
    else $error("drive on in shutdown");
  a_shutdown_fail_off: assert property (ce_in && shutdown_in |=> fail_n_out)
    else $error("failure shown in shutdown");
  a_fail_latched: assert property (!fail_n_out && !shutdown_in |=> !fail_n_out)
    else $error("failure released");
  a_fail_no_drive: assert property (!fail_n_out |-> !drive_out)
    else $error("drive on with failure");
  a_start_spin: assert property (ce_in && $past(ce_in) && !shutdown_in && $past(shutdown_in)
    |=> drive_out[*8])
    else $error("no spin-up after release");
  a_ce_freeze: assert property (!ce_in |=> $stable(drive_out) && $stable(fail_n_out))
    else $error("outputs moved while frozen");
  a_reset_outs: assert property ($fell(rst_in) |-> !drive_out && fail_n_out)
    else $error("outputs wrong after reset");
  a_fail_too_soon: assert property ($fell(fail_n_out) |-> run_cnt >= MIN_FAIL)
    else $error("failure before two spin-ups");
endmodule : fan_sup_asserts
bind fan_pwm_fault_supervisor fan_sup_asserts #(.TICK_DIV(TICK_DIV)) i_chk (
  .clk_in, .rst_in, .ce_in, .shutdown_in, .drive_out, .fail_n_out);
`default_nettype wire

// file: testbench/fan_model.sv
/* fan stand-in giving commutation pulses.
   assumes the bench starts and stalls the rotor. */
`timescale 1ns/1ps
`default_nettype none
module fan_model (
  // clock and rotor
  input wire logic clk_in,
  input wire logic alive_in,
  // sense line
  output logic sense_out = 1'b0
);
  int unsigned phase = 0;
  // stalled rotor leaves the line low, as the pull-down would
  always @(posedge clk_in) begin
    phase <= (phase == 96) ? 0 : phase + 1;
    sense_out <= alive_in && (phase < 3);
  end
endmodule : fan_model
`default_nettype wire

// file: testbench/fan_pwm_fault_supervisor_tb_top.sv
/* bench: spin-up, failure latch, shutdown, duty.
   assumes fan_model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module fan_pwm_fault_supervisor_tb_top;
  localparam int TD = 2;
  localparam int P = TD * 255;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic [7:0] temp_code = 8'h00;
  logic [7:0] min_code = 8'h00;
  logic shutdown = 1'b0;
  logic alive = 1'b0;
  logic sense;
  logic drive;
  logic fail_n;
  int fail_count = 0;
  int compares = 0;
  always #5 clk_in = ~clk_in;
  fan_model i_fan (.clk_in(clk_in), .alive_in(alive), .sense_out(sense));
  fan_pwm_fault_supervisor #(.TICK_DIV(TD)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .ce_in(ce_in), .temp_code_in(temp_code), .min_code_in(min_code),
    .shutdown_in(shutdown), .sense_in(sense), .drive_out(drive), .fail_n_out(fail_n));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_p(input int n);
    repeat (n * P) @(posedge clk_in);
    #1;
  endtask : wait_p
  function automatic logic [15:0] duty_of(input int t, input int m);
    return 16'((t > m ? t : m) * TD);
  endfunction : duty_of
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #(195 * P * 10);
    fail_count++;
    finish_test();
  end
  initial begin
    logic [15:0] hi;
    int t;
    int m;
    void'($urandom(32'h3d15));
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    wait_p(31);
    chk(drive, 1'b1);
    wait_p(9);
    chk(drive, 1'b1);
    wait_p(26);
    chk({drive, fail_n}, 2'b00);
    wait_p(2);
    chk(fail_n, 1'b0);
    $display("test dead_rotor done");
    @(posedge clk_in);
    shutdown <= 1'b1;
    temp_code <= 8'hff;
    alive <= 1'b1;
    wait_p(1);
    chk({drive, fail_n}, 2'b01);
    @(posedge clk_in);
    shutdown <= 1'b0;
    repeat (20) @(posedge clk_in);
    ce_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    ce_in <= 1'b1;
    wait_p(33);
    chk({drive, fail_n}, 2'b11);
    $display("test restart done");
    // corners first, then random codes
    for (int i = 0; i < 5; i++) begin
      t = (i == 0) ? 0 : (i == 1) ? 255 : $urandom % 256;
      m = (i == 0) ? 0 : $urandom % 256;
      @(posedge clk_in);
      temp_code <= 8'(t);
      min_code <= 8'(m);
      wait_p(1);
      hi = '0;
      repeat (P) begin
        @(posedge clk_in);
        #1;
        hi = hi + 16'(drive);
      end
      chk(hi, duty_of(t, m));
    end
    $display("test duty done");
    @(posedge clk_in);
    temp_code <= 8'h00;
    min_code <= 8'h00;
    alive <= 1'b0;
    wait_p(20);
    chk(drive, 1'b0);
    wait_p(14);
    chk(drive, 1'b1);
    wait_p(16);
    chk({drive, fail_n}, 2'b11);
    wait_p(22);
    chk({drive, fail_n}, 2'b00);
    $display("test stall done");
    // failure fed back as a shutdown pulse, held one period by outside logic
    @(posedge clk_in);
    shutdown <= 1'b1;
    wait_p(1);
    chk({drive, fail_n}, 2'b01);
    @(posedge clk_in);
    shutdown <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    chk({drive, fail_n}, 2'b11);
    $display("test retry done");
    finish_test();
  end
endmodule : fan_pwm_fault_supervisor_tb_top
`default_nettype wire
